// ---- logic/lmps_defines.vh ----
/*
 Constants for the LED and mirror power control with start-up straps.
 Assumes a 50 MHz system clock.
*/
`ifndef LMPS_DEFINES_VH
`define LMPS_DEFINES_VH
`define LMPS_CLK_HZ            50000000
`define LMPS_LED_DLY_MS        100
`define LMPS_LED_DLY_CYC       ((`LMPS_CLK_HZ / 1000) * `LMPS_LED_DLY_MS)
`define LMPS_MIR_HOLD_US       500
`define LMPS_MIR_HOLD_CYC      ((`LMPS_CLK_HZ / 1000000) * `LMPS_MIR_HOLD_US)
`define LMPS_SEL_NONE          2'h0
`define LMPS_SEL_RED           2'h1
`define LMPS_SEL_GREEN         2'h2
`define LMPS_SEL_BLUE          2'h3
`define LMPS_I2C_WR_LO         8'h36
`define LMPS_I2C_RD_LO         8'h37
`define LMPS_I2C_WR_HI         8'h3a
`define LMPS_I2C_RD_HI         8'h3b
`define LMPS_REFERENCE_CLOCK_16M        1'b0
`define LMPS_REFERENCE_CLOCK_48M        1'b1
`define LMPS_NUM_TEST          6
`define LMPS_SAR_BITS          8
`define LMPS_SAR_SETTLE        16
`endif

// ---- logic/lmps_sar.v ----
/*
 Successive-approximation converter against an external comparator.
 Drives a PWM reference; comparator result must already be synchronised.
 Comparator high means the input is above the reference.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lmps_defines.vh"
module lmps_sar #(
    parameter N      = `LMPS_SAR_BITS,
    parameter SETTLE = `LMPS_SAR_SETTLE
) (
    // Clock and reset
    input  wire         i_clk,
    input  wire         i_rst,
    // Control
    input  wire         i_start,
    output wire         o_busy,
    output reg          o_done,
    output reg  [N-1:0] o_result,
    // Comparator
    output reg          o_pwm,
    input  wire         i_cmp
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RUN  = 2'h1;
    reg [1:0]   state_r;
    reg [N-1:0] trial_r;
    reg [N-1:0] bit_r;
    reg [N-1:0] pwm_cnt_r;
    reg [15:0]  settle_r;
    assign o_busy = (state_r == ST_RUN);
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r   <= ST_IDLE;
            trial_r   <= {N{1'b0}};
            bit_r     <= {N{1'b0}};
            pwm_cnt_r <= {N{1'b0}};
            settle_r  <= 16'h0000;
            o_done    <= 1'b0;
            o_result  <= {N{1'b0}};
            o_pwm     <= 1'b0;
        end
        else
        begin
            o_done    <= 1'b0;
            pwm_cnt_r <= pwm_cnt_r + 1'b1;
            o_pwm     <= (pwm_cnt_r < trial_r);
            case (state_r)
                ST_IDLE:
                begin
                    if (i_start)
                    begin
                        state_r  <= ST_RUN;
                        bit_r    <= {1'b1, {(N-1){1'b0}}};
                        trial_r  <= {1'b1, {(N-1){1'b0}}};
                        settle_r <= 16'h0000;
                    end
                end
                ST_RUN:
                begin
                    // Reference is filtered externally; wait whole PWM periods
                    if (settle_r == SETTLE[15:0] - 16'h0001)
                    begin
                        settle_r <= 16'h0000;
                        if (!i_cmp)
                            trial_r <= (trial_r & ~bit_r) | (bit_r >> 1);
                        else
                            trial_r <= trial_r | (bit_r >> 1);
                        bit_r <= bit_r >> 1;
                        if (bit_r[0])
                        begin
                            o_result <= i_cmp ? trial_r : (trial_r & ~bit_r);
                            o_done   <= 1'b1;
                            state_r  <= ST_IDLE;
                        end
                    end
                    else if (pwm_cnt_r == {N{1'b1}})
                        settle_r <= settle_r + 16'h0001;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
endmodule // lmps_sar
`default_nettype wire

// ---- logic/lmps_sync.v ----
/*
 Two-flop synchroniser for a bus of asynchronous levels.
 Assumes inputs are quasi-static relative to i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module lmps_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         i_clk,
    input  wire         i_rst,
    // Data
    input  wire [W-1:0] i_d,
    output reg  [W-1:0] o_q
);
    reg [W-1:0] meta_r;
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_r <= {W{1'b0}};
            o_q    <= {W{1'b0}};
        end
        else
        begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end
endmodule // lmps_sync
`default_nettype wire

// ---- logic/lmps_top.v ----
/*
 LED driver enable, colour select, mirror regulator enable, test-pin straps,
 focus motor pins and light-sensor converter.
 Assumes i_clk at 50 MHz and i_rst asserted from the device reset pin.
*/
// Overview of operation
// - Colour select code: 00 none, 01 red, 10 green, 11 blue.
// - LED master enable rises 100 ms after Input_a goes high.
// - LED master enable drops at once when Input_a or power good drops.
// - Mirror regulator enable is high while power good is high.
// - Mirror regulator enable stays high 500 us after power good falls.
// - Without companion chip, PWM outputs forced high when LED path inactive.
// - Test pins are sampled at reset release, then driven as outputs.
// - Low auto-init strap enables flash auto-init; high allows I2C programming.
// - Reference-clock strap selects assumed 16.67 or 48.67 MHz PLL input.
// - Address strap low gives 0x36/0x37, high gives 0x3A/0x3B.
// - Successive approximation with PWM reference and comparator input.
// - Focus motor: pin 0 driver enable, pins 1 to 4 data LSB to MSB.
// - Input_a low holds master enable low and select at 00.
`timescale 1ns/1ps
`default_nettype none
`include "lmps_defines.vh"
module lmps_top #(
    parameter LED_DLY_CYC  = `LMPS_LED_DLY_CYC,
    parameter MIR_HOLD_CYC = `LMPS_MIR_HOLD_CYC,
    parameter SAR_BITS     = `LMPS_SAR_BITS
) (
    // Clock and reset
    input  wire                      i_clk,
    input  wire                      i_rst,
    // Power and LED control pins
    input  wire                      i_input_a,
    input  wire                      i_power_good,
    output reg                       o_led_driver_master_enable,
    output reg  [1:0]                o_led_colour_select,
    output reg                       o_mirror_regulator_enable,
    // Sequencer side
    input  wire [1:0]                i_seq_colour,
    input  wire                      i_seq_running,
    input  wire                      i_sw_input_a,
    input  wire                      i_companion_present,
    input  wire [2:0]                i_pwm_rgb,
    output reg                       o_red_led_pwm,
    output reg                       o_green_led_pwm,
    output reg                       o_blue_led_pwm,
    // Test pins 0..5 and straps
    input  wire [`LMPS_NUM_TEST-1:0] i_test_pin,
    output reg  [`LMPS_NUM_TEST-1:0] o_test_pin,
    output reg  [`LMPS_NUM_TEST-1:0] o_test_pin_oe,
    input  wire                      i_reference_clock_select_strap,
    output reg                       o_reference_clock_select_strap,
    output reg                       o_reference_clock_select_strap_oe,
    input  wire                      i_i2c_address_strap,
    output reg                       o_i2c_address_strap,
    output reg                       o_i2c_address_strap_oe,
    input  wire [`LMPS_NUM_TEST-1:0] i_test_out_data,
    // Strap results
    output reg  [`LMPS_NUM_TEST-1:0] o_test_mode,
    output reg                       o_auto_init_enable,
    output reg                       o_reference_clock_48m,
    output reg  [7:0]                o_i2c_write_addr,
    output reg  [7:0]                o_i2c_read_addr,
    output reg                       o_straps_valid,
    // Focus motor
    input  wire                      i_focus_mode,
    input  wire                      i_motor_enable,
    input  wire [3:0]                i_motor_data,
    // Light sensor
    input  wire                      i_sar_start,
    input  wire                      i_comparator_result_in,
    output wire                      o_comparator_pwm_reference,
    output wire                      o_sar_busy,
    output wire                      o_sar_done,
    output wire [SAR_BITS-1:0]       o_sar_result,
    input  wire                      i_sensor_power_on,
    output reg                       o_sensor_power_control
);
    localparam NS = `LMPS_NUM_TEST + 5;

    // All pin levels pass two flops before use
    wire [NS-1:0] sync_q;
    lmps_sync #(
        .W (NS)
    ) u_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   ({i_comparator_result_in, i_i2c_address_strap, i_reference_clock_select_strap,
                 i_test_pin, i_power_good, i_input_a}),
        .o_q   (sync_q)
    );
    wire                      led_en_s = sync_q[0];
    wire                      pgood_s  = sync_q[1];
    wire [`LMPS_NUM_TEST-1:0] test_s   = sync_q[`LMPS_NUM_TEST+1:2];
    wire                      reference_clock_s = sync_q[`LMPS_NUM_TEST+2];
    wire                      addr_s   = sync_q[`LMPS_NUM_TEST+3];
    wire                      cmp_s    = sync_q[`LMPS_NUM_TEST+4];

    // Straps: sampled after reset release once the sync chain has refilled
    reg [1:0] strap_cnt_r;
    reg       strap_done_r;
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            strap_cnt_r        <= 2'h0;
            strap_done_r       <= 1'b0;
            o_test_mode        <= {`LMPS_NUM_TEST{1'b0}};
            o_auto_init_enable <= 1'b0;
            o_reference_clock_48m       <= `LMPS_REFERENCE_CLOCK_16M;
            o_i2c_write_addr   <= `LMPS_I2C_WR_LO;
            o_i2c_read_addr    <= `LMPS_I2C_RD_LO;
            o_straps_valid     <= 1'b0;
        end
        else if (!strap_done_r)
        begin
            if (strap_cnt_r == 2'h2)
            begin
                strap_done_r       <= 1'b1;
                o_straps_valid     <= 1'b1;
                o_test_mode        <= test_s;
                o_auto_init_enable <= ~test_s[4];
                o_reference_clock_48m       <= reference_clock_s ? `LMPS_REFERENCE_CLOCK_48M : `LMPS_REFERENCE_CLOCK_16M;
                o_i2c_write_addr   <= addr_s ? `LMPS_I2C_WR_HI : `LMPS_I2C_WR_LO;
                o_i2c_read_addr    <= addr_s ? `LMPS_I2C_RD_HI : `LMPS_I2C_RD_LO;
            end
            else
                strap_cnt_r <= strap_cnt_r + 2'h1;
        end
    end

    // Test pins: inputs until straps taken, then outputs
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_test_pin               <= {`LMPS_NUM_TEST{1'b0}};
            o_test_pin_oe            <= {`LMPS_NUM_TEST{1'b0}};
            o_reference_clock_select_strap    <= 1'b0;
            o_reference_clock_select_strap_oe <= 1'b0;
            o_i2c_address_strap      <= 1'b0;
            o_i2c_address_strap_oe   <= 1'b0;
        end
        else if (strap_done_r)
        begin
            o_test_pin_oe            <= {`LMPS_NUM_TEST{1'b1}};
            o_reference_clock_select_strap_oe <= 1'b1;
            o_i2c_address_strap_oe   <= 1'b1;
            o_reference_clock_select_strap    <= 1'b0;
            o_i2c_address_strap      <= 1'b0;
            if (i_focus_mode)
                o_test_pin <= {i_test_out_data[5], i_motor_data, i_motor_enable};
            else
                o_test_pin <= i_test_out_data;
        end
    end

    // Input_a delay; counter clears whenever LED path is off
    reg [31:0] led_cnt_r;
    wire       led_ok = led_en_s & pgood_s;
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            led_cnt_r <= 32'h0;
        else if (!led_ok)
            led_cnt_r <= 32'h0;
        else if (led_cnt_r != LED_DLY_CYC[31:0])
            led_cnt_r <= led_cnt_r + 32'h1;
    end
    // Master enable gated combinationally from sync'd levels so drop is immediate
    always @*
    begin
        o_led_driver_master_enable = led_ok && (led_cnt_r == LED_DLY_CYC[31:0]);
    end

    // Colour select follows sequencer only while the LED path is enabled
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_led_colour_select <= `LMPS_SEL_NONE;
        else if (!o_led_driver_master_enable)
            o_led_colour_select <= `LMPS_SEL_NONE;
        else
            o_led_colour_select <= i_seq_colour;
    end

    // PWM outputs; idle-high so a discrete decoder turns all LEDs off
    wire pwm_force = ~i_companion_present &
                     (~o_led_driver_master_enable | ~i_sw_input_a | ~i_seq_running);
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_red_led_pwm   <= 1'b1;
            o_green_led_pwm <= 1'b1;
            o_blue_led_pwm  <= 1'b1;
        end
        else
        begin
            o_red_led_pwm   <= pwm_force | i_pwm_rgb[0];
            o_green_led_pwm <= pwm_force | i_pwm_rgb[1];
            o_blue_led_pwm  <= pwm_force | i_pwm_rgb[2];
        end
    end

    // Mirror regulator enable with hold-off after power good falls
    reg [31:0] mir_cnt_r;
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            mir_cnt_r                 <= 32'h0;
            o_mirror_regulator_enable <= 1'b0;
        end
        else if (pgood_s)
        begin
            mir_cnt_r                 <= 32'h0;
            o_mirror_regulator_enable <= 1'b1;
        end
        else if (o_mirror_regulator_enable)
        begin
            if (mir_cnt_r == MIR_HOLD_CYC[31:0] - 32'h1)
                o_mirror_regulator_enable <= 1'b0;
            else
                mir_cnt_r <= mir_cnt_r + 32'h1;
        end
    end

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_sensor_power_control <= 1'b0;
        else
            o_sensor_power_control <= i_sensor_power_on;
    end

    lmps_sar #(
        .N      (SAR_BITS),
        .SETTLE (`LMPS_SAR_SETTLE)
    ) u_sar (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_start  (i_sar_start),
        .o_busy   (o_sar_busy),
        .o_done   (o_sar_done),
        .o_result (o_sar_result),
        .o_pwm    (o_comparator_pwm_reference),
        .i_cmp    (cmp_s)
    );
endmodule // lmps_top
`default_nettype wire

// ---- verification/led_mirror_power_straps_tb.sv ----
/*
 Self-checking bench for lmps_top with a board model.
 Assumes the 50 MHz clock and shortened delay counts below.
*/
`timescale 1ns/1ps
`default_nettype none
module led_mirror_power_straps_tb;
    localparam LED_DLY_CYC  = 50;
    localparam MIR_HOLD_CYC = 20;
    logic i_clk = 1'b0, i_rst = 1'b1, i_input_a = 1'b0, i_power_good = 1'b1, i_seq_running = 1'b0;
    logic i_sw_input_a = 1'b0, i_companion_present = 1'b0, i_focus_mode = 1'b0, i_motor_enable = 1'b0;
    logic i_sar_start = 1'b0, i_sensor_power_on = 1'b0, sense = 1'b0;
    logic [1:0] i_seq_colour = 2'h0;
    logic [2:0] i_pwm_rgb = 3'h0;
    logic [3:0] i_motor_data = 4'h0;
    logic [5:0] i_test_out_data = 6'h0;
    logic [7:0] pull_up = 8'h0;
    logic [31:0] seed = 32'd77266;
    logic [31:0] v;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    wire o_led_driver_master_enable, o_mirror_regulator_enable, o_red_led_pwm, o_green_led_pwm, o_blue_led_pwm;
    wire o_reference_clock_select_strap, o_reference_clock_select_strap_oe, o_i2c_address_strap, o_i2c_address_strap_oe;
    wire o_auto_init_enable, o_reference_clock_48m, o_straps_valid, o_sar_done, cmp, o_sar_busy, o_sensor_power_control;
    wire [1:0] o_led_colour_select;
    wire [5:0] o_test_pin, o_test_pin_oe, o_test_mode;
    wire [7:0] o_i2c_write_addr, o_i2c_read_addr, o_sar_result, pin;
    lmps_top #(.LED_DLY_CYC(LED_DLY_CYC), .MIR_HOLD_CYC(MIR_HOLD_CYC)) uut (
        .i_clk, .i_rst, .i_input_a, .i_power_good, .o_led_driver_master_enable, .o_led_colour_select,
        .o_mirror_regulator_enable, .i_seq_colour, .i_seq_running, .i_sw_input_a, .i_companion_present,
        .i_pwm_rgb, .o_red_led_pwm, .o_green_led_pwm, .o_blue_led_pwm, .i_test_pin(pin[5:0]), .o_test_pin,
        .o_test_pin_oe, .i_reference_clock_select_strap(pin[6]), .o_reference_clock_select_strap, .o_reference_clock_select_strap_oe,
        .i_i2c_address_strap(pin[7]), .o_i2c_address_strap, .o_i2c_address_strap_oe, .i_test_out_data,
        .o_test_mode, .o_auto_init_enable, .o_reference_clock_48m, .o_i2c_write_addr, .o_i2c_read_addr, .o_straps_valid,
        .i_focus_mode, .i_motor_enable, .i_motor_data, .i_sar_start, .i_comparator_result_in(cmp),
        .o_comparator_pwm_reference(), .o_sar_busy, .o_sar_done, .o_sar_result, .i_sensor_power_on,
        .o_sensor_power_control);
    lmps_board board (.i_oe({o_i2c_address_strap_oe, o_reference_clock_select_strap_oe, o_test_pin_oe}),
        .i_drv({o_i2c_address_strap, o_reference_clock_select_strap, o_test_pin}), .i_pull_up(pull_up),
        .i_sense_high(sense), .o_pin(pin), .o_cmp(cmp));
    always #10 i_clk = ~i_clk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] exp_wr(input logic s);
        return s ? 8'h3a : 8'h36;
    endfunction
    function automatic logic [2:0] exp_pwm(input logic f, input logic [2:0] rgb);
        return f ? 3'h7 : rgb;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    initial
    begin
        // Three resets: all straps low, all high, random; later ones land mid-run
        for (int k = 0; k < 3; k++)
        begin
            @(posedge i_clk);
            i_rst <= 1'b1;
            v = rnd();
            pull_up <= (k == 0) ? 8'h00 : (k == 1) ? 8'hff : v[7:0];
            tick(4);
            chk({6'h0, o_mirror_regulator_enable, o_led_driver_master_enable}, 8'h00);
            @(posedge i_clk);
            i_rst <= 1'b0;
            tick(8);
            chk({2'h0, o_test_mode}, {2'h0, pull_up[5:0]});
            chk({7'h0, o_auto_init_enable}, {7'h0, ~pull_up[4]});
            chk({7'h0, o_reference_clock_48m}, {7'h0, pull_up[6]});
            chk(o_i2c_write_addr, exp_wr(pull_up[7]));
            chk(o_i2c_read_addr, exp_wr(pull_up[7]) + 8'h01);
            chk({o_i2c_address_strap_oe, o_reference_clock_select_strap_oe, o_test_pin_oe}, 8'hff);
        end
        i_focus_mode <= 1'b1;
        repeat (4)
        begin
            @(posedge i_clk);
            v = rnd();
            i_motor_enable <= v[4];
            i_motor_data <= v[3:0];
            tick(2);
            chk({3'h0, pin[4:0]}, {3'h0, v[3:0], v[4]});
        end
        for (int k = 0; k < 2; k++)
        begin
            @(posedge i_clk);
            i_input_a <= 1'b1;
            tick(LED_DLY_CYC - 4);
            chk({7'h0, o_led_driver_master_enable}, 8'h00);
            tick(10);
            chk({7'h0, o_led_driver_master_enable}, 8'h01);
            for (int c = 0; c < 4; c++)
            begin
                @(posedge i_clk);
                i_seq_colour <= c[1:0];
                tick(3);
                chk({6'h0, o_led_colour_select}, c[7:0]);
            end
            @(posedge i_clk);
            i_input_a <= k[0];
            i_power_good <= ~k[0];
            tick(2);
            chk({7'h0, o_led_driver_master_enable}, 8'h00);
        end
        tick(MIR_HOLD_CYC - 7);
        chk({7'h0, o_mirror_regulator_enable}, 8'h01);
        tick(10);
        chk({6'h0, o_led_colour_select}, 8'h00);
        chk({7'h0, o_mirror_regulator_enable}, 8'h00);
        @(posedge i_clk);
        i_power_good <= 1'b1;
        tick(LED_DLY_CYC + 10);
        chk({7'h0, o_mirror_regulator_enable}, 8'h01);
        for (int k = 0; k < 8; k++)
        begin
            @(posedge i_clk);
            v = rnd();
            {i_companion_present, i_sw_input_a, i_seq_running} <= k[2:0];
            i_pwm_rgb <= v[2:0];
            i_sensor_power_on <= v[3];
            i_test_out_data <= v[13:8];
            tick(2);
            chk({5'h0, o_blue_led_pwm, o_green_led_pwm, o_red_led_pwm},
                {5'h0, exp_pwm(~k[2] & ~(k[1] & k[0]), v[2:0])});
            chk({7'h0, o_sensor_power_control}, {7'h0, v[3]});
        end
        // Sensor below, then above every reference
        for (int k = 0; k < 2; k++)
        begin
            @(posedge i_clk);
            sense <= k[0];
            tick(4);
            @(posedge i_clk);
            i_sar_start <= 1'b1;
            @(posedge i_clk);
            i_sar_start <= 1'b0;
            tick(1);
            chk({7'h0, o_sar_busy}, 8'h01);
            for (int n = 0; n < 40000 && o_sar_done !== 1'b1; n++)
                tick(1);
            chk({7'h0, o_sar_done}, 8'h01);
            chk(o_sar_result, {8{k[0]}});
        end
        print_verdict();
    end
endmodule // led_mirror_power_straps_tb
bind lmps_top lmps_props #(.LED_DLY_CYC(LED_DLY_CYC), .MIR_HOLD_CYC(MIR_HOLD_CYC)) u_props (
    .i_clk, .i_rst, .i_input_a, .i_power_good, .o_led_driver_master_enable, .o_led_colour_select,
    .o_mirror_regulator_enable, .i_seq_colour, .i_seq_running, .i_sw_input_a, .i_companion_present,
    .o_red_led_pwm, .o_green_led_pwm, .o_blue_led_pwm, .o_test_pin, .o_straps_valid, .i_focus_mode,
    .i_motor_enable, .i_motor_data);
`default_nettype wire

// ---- verification/lmps_board.sv ----
/*
 Board model: strap resistors on the test pins and the light-sensor comparator.
 Assumes pin index 5:0 test pins, 6 clock strap, 7 address strap.
*/
`timescale 1ns/1ps
`default_nettype none
module lmps_board (
    // Device pin drive
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_drv,
    // Board fit
    input  wire logic [7:0] i_pull_up,
    input  wire logic       i_sense_high,
    // Levels seen by the device
    output wire logic [7:0] o_pin,
    output wire logic       o_cmp
);
    // Released pins fall to their resistor; pull-ups only where a strap is meant
    assign o_pin = (i_oe & i_drv) | (~i_oe & i_pull_up);
    // Sensor either above or below every reference the device makes
    assign o_cmp = i_sense_high;
endmodule // lmps_board
`default_nettype wire

// ---- verification/lmps_top_properties.sv ----
/*
 Timing checker for the LED, mirror regulator, PWM and motor pins of lmps_top.
 Bound to lmps_top; sees its ports only, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lmps_defines.vh"
module lmps_props #(
    parameter LED_DLY_CYC  = 50,
    parameter MIR_HOLD_CYC = 20
) (
    // Clock and reset
    input wire logic                      i_clk,
    input wire logic                      i_rst,
    // Power and LED
    input wire logic                      i_input_a,
    input wire logic                      i_power_good,
    input wire logic                      o_led_driver_master_enable,
    input wire logic [1:0]                o_led_colour_select,
    input wire logic                      o_mirror_regulator_enable,
    input wire logic [1:0]                i_seq_colour,
    input wire logic                      i_seq_running,
    input wire logic                      i_sw_input_a,
    input wire logic                      i_companion_present,
    input wire logic                      o_red_led_pwm,
    input wire logic                      o_green_led_pwm,
    input wire logic                      o_blue_led_pwm,
    // Test pins and motor
    input wire logic [`LMPS_NUM_TEST-1:0] o_test_pin,
    input wire logic                      o_straps_valid,
    input wire logic                      i_focus_mode,
    input wire logic                      i_motor_enable,
    input wire logic [3:0]                i_motor_data
);
    // Raw pin run lengths, saturating so long idle spans never wrap
    logic [15:0] on_cnt_r;
    logic [15:0] lo_cnt_r;
    wire         force_w = !i_companion_present && !(o_led_driver_master_enable && i_sw_input_a && i_seq_running);
    wire         motor_w = o_straps_valid && i_focus_mode;
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            on_cnt_r <= 16'h0;
            lo_cnt_r <= 16'h0;
        end
        else
        begin
            on_cnt_r <= (i_input_a && i_power_good) ? on_cnt_r + {15'h0, ~&on_cnt_r} : 16'h0;
            lo_cnt_r <= !i_power_good ? lo_cnt_r + {15'h0, ~&lo_cnt_r} : 16'h0;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_sel_follow; $past(o_led_driver_master_enable) |-> o_led_colour_select == $past(i_seq_colour); endproperty
    a_sel_follow: assert property (p_sel_follow) else $error("select differs from colour");
    property p_sel_idle; o_led_colour_select != 2'h0 |-> $past(o_led_driver_master_enable); endproperty
    a_sel_idle: assert property (p_sel_idle) else $error("select set while disabled");
    property p_led_early; $rose(o_led_driver_master_enable) |-> on_cnt_r >= LED_DLY_CYC; endproperty
    a_led_early: assert property (p_led_early) else $error("master enable early");
    property p_led_late; on_cnt_r >= LED_DLY_CYC + 5 |-> o_led_driver_master_enable; endproperty
    a_led_late: assert property (p_led_late) else $error("master enable late");
    property p_led_drop; (!i_input_a || !i_power_good) |-> ##2 !o_led_driver_master_enable; endproperty
    a_led_drop: assert property (p_led_drop) else $error("master enable not dropped");
    property p_mir_on; i_power_good [*5] |-> o_mirror_regulator_enable; endproperty
    a_mir_on: assert property (p_mir_on) else $error("mirror enable low");
    property p_mir_hold; $fell(o_mirror_regulator_enable) |-> lo_cnt_r >= MIR_HOLD_CYC; endproperty
    a_mir_hold: assert property (p_mir_hold) else $error("mirror enable dropped early");
    property p_mir_off; lo_cnt_r >= MIR_HOLD_CYC + 5 |-> !o_mirror_regulator_enable; endproperty
    a_mir_off: assert property (p_mir_off) else $error("mirror enable dropped late");
    property p_pwm_force; $past(force_w) |-> o_red_led_pwm && o_green_led_pwm && o_blue_led_pwm; endproperty
    a_pwm_force: assert property (p_pwm_force) else $error("pwm not forced");
    property p_motor; $past(motor_w) |-> o_test_pin[4:0] == {$past(i_motor_data), $past(i_motor_enable)}; endproperty
    a_motor: assert property (p_motor) else $error("motor pins wrong");
endmodule // lmps_props
`default_nettype wire
